// ===== logic/psc_top.sv
`timescale 1ns/100ps
// Functional notes
// R1: The configuration word sits at index 0x39 and is all zeros after reset.
// R2: Software writes zero to the reserved top bit.
// R3: The calibration-range bit doubles the resistive string voltage for internal gain calibration.
// R4: With indicator routing set, pin four ignores its own enable and value and shows the standby indicator.
// R5: That indicator is active low: low in standby, high while converting.
// R6: With indicator routing clear, pin four follows its ordinary enable and value.
// R7: The standby diagnostics bit keeps the enabled diagnostics alive in standby.
// R8: Overvoltage and undervoltage detection works only while an oscillator runs.
// R9: In standby the internal oscillator stops when nothing enabled needs it.
// R10: The diagnostics bit keeps the internal oscillator on only with a qualifying error enabled and internal clock chosen.
module psc_top #(
   parameter int N_OVUV = 4 // Number of voltage error enables
) (
   input wire logic clk, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic [psc_pkg::PSC_ADDR_W-1:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [psc_pkg::PSC_ADDR_W-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic inStandby, // Device is in standby
   input wire psc_pkg::psc_pin_t pinFourCtrl, // Ordinary pin four settings
   input wire logic [N_OVUV-1:0] ovUvErrEnable, // Voltage error enables
   input wire logic clkSelInternal, // Internal oscillator chosen
   input wire logic extClkRunning, // External clock present
   output psc_pkg::psc_pin_t pinFour, // Pin four drive
   output logic analogRegulatorOff, // Analog regulator off
   output logic calRangeDouble, // Double calibration string voltage
   output logic intOscEnable, // Internal oscillator on
   output logic [N_OVUV-1:0] ovUvDetectEnable // Voltage detectors live
);
   import psc_pkg::*;

   // ----------------------------------------
   // Elaboration check
   // ----------------------------------------
   generate
      if (N_OVUV < 1 || N_OVUV > 16) begin : g_bad
         $error("N_OVUV out of range");
      end
   endgenerate

   // ----------------------------------------
   // Write channel
   // ----------------------------------------
   logic awReady_q, wReady_q, bValid_q, awHeld_q, wHeld_q;
   logic [1:0] bResp_q;
   logic [9:0] awIdx_q;
   logic [15:0] wData_q;
   logic [1:0] wStrb_q;
   wire awTake = s_axi_awvalid & awReady_q;
   wire wTake = s_axi_wvalid & wReady_q;
   wire doWrite = awHeld_q & wHeld_q;
   wire bDone = bValid_q & s_axi_bready;
   wire awHeld_d = (awHeld_q | awTake) & ~doWrite;
   wire wHeld_d = (wHeld_q | wTake) & ~doWrite;
   wire bValid_d = doWrite | (bValid_q & ~bDone);
   wire cfgWrite = doWrite & (awIdx_q == PSC_CFG_IDX); // see R1
   wire [1:0] bResp_d = cfgWrite ? PSC_RESP_OKAY : PSC_RESP_SLVERR;

   // Address and data are accepted in either order, one write at a time
   always_ff @(posedge clk) begin
      if (rst) begin
         awReady_q <= 1'b0;
         wReady_q <= 1'b0;
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         bValid_q <= 1'b0;
         bResp_q <= PSC_RESP_OKAY;
      end else begin
         awReady_q <= ~awHeld_d & ~bValid_d;
         wReady_q <= ~wHeld_d & ~bValid_d;
         awHeld_q <= awHeld_d;
         wHeld_q <= wHeld_d;
         bValid_q <= bValid_d;
         if (doWrite) begin
            bResp_q <= bResp_d;
         end
      end
   end

   // Payload capture; no reset needed, guarded by the held flags
   always_ff @(posedge clk) begin
      if (awTake) begin
         awIdx_q <= s_axi_awaddr[PSC_ADDR_W-1:2];
      end
      if (wTake) begin
         wData_q <= s_axi_wdata[15:0];
         wStrb_q <= s_axi_wstrb[1:0];
      end
   end

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   psc_cfg_t cfgQ;

   psc_cfg_word u_cfg (
      .clk(clk),
      .rst(rst),
      .we(cfgWrite),
      .wdata(wData_q),
      .wstrb(wStrb_q),
      .q(cfgQ)
   );

   // ----------------------------------------
   // Standby behaviour
   // ----------------------------------------
   // Oscillator kept only when a keep request has something to serve
   wire oscKeep = cfgQ.standbyDiagKeep & (|ovUvErrEnable) & clkSelInternal; // see R10
   wire intOsc_d = ~inStandby | oscKeep; // see R9
   // An external clock counts as running only if the host says so
   wire clkAvail = clkSelInternal ? intOsc_d : extClkRunning; // see R8
   wire diagLive = ~inStandby | cfgQ.standbyDiagKeep; // see R7
   wire standbyInd = ~inStandby; // see R5
   psc_pin_t pin_d;
   assign pin_d = cfgQ.standbyIndicatorRoute ? psc_pin_t'{oe: 1'b1, val: standbyInd} : pinFourCtrl; // see R4 see R6
   logic [N_OVUV-1:0] ovUv_d;

   // Each voltage detector gated alike
   genvar i;
   generate
      for (i = 0; i < N_OVUV; i++) begin : g_ovuv
         assign ovUv_d[i] = ovUvErrEnable[i] & diagLive & clkAvail; // see R7 see R8
      end
   endgenerate

   logic [2:0] stat_q;
   wire [2:0] stat_d = {diagLive, standbyInd, intOsc_d};

   // Registered outputs to the analog side
   always_ff @(posedge clk) begin
      if (rst) begin
         pinFour <= '0;
         analogRegulatorOff <= 1'b0;
         calRangeDouble <= 1'b0;
         intOscEnable <= 1'b0;
         ovUvDetectEnable <= '0;
         stat_q <= PSC_STAT_RESET;
      end else begin
         pinFour <= pin_d;
         analogRegulatorOff <= cfgQ.analogRegulatorOff;
         calRangeDouble <= cfgQ.calRangeDouble; // see R3
         intOscEnable <= intOsc_d;
         ovUvDetectEnable <= ovUv_d;
         stat_q <= stat_d;
      end
   end

   // ----------------------------------------
   // Read channel
   // ----------------------------------------
   logic arReady_q, rValid_q;
   logic [1:0] rResp_q;
   logic [31:0] rData_q;
   wire arTake = s_axi_arvalid & arReady_q;
   wire rValid_d = arTake | (rValid_q & ~s_axi_rready);
   wire [9:0] arIdx = s_axi_araddr[PSC_ADDR_W-1:2];
   wire hitCfg = (arIdx == PSC_CFG_IDX);
   wire hitStat = (arIdx == PSC_STAT_IDX);
   wire [31:0] rSel = hitCfg ? {16'h0000, cfgQ} : (hitStat ? {29'h0, stat_q} : 32'h0);
   wire [1:0] rRespSel = (hitCfg | hitStat) ? PSC_RESP_OKAY : PSC_RESP_SLVERR;

   // Data captured at the address handshake, shown the next cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         arReady_q <= 1'b0;
         rValid_q <= 1'b0;
         rResp_q <= PSC_RESP_OKAY;
         rData_q <= 32'h0;
      end else begin
         arReady_q <= ~rValid_d;
         rValid_q <= rValid_d;
         if (arTake) begin
            rData_q <= rSel;
            rResp_q <= rRespSel;
         end
      end
   end

   assign s_axi_awready = awReady_q;
   assign s_axi_wready = wReady_q;
   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;
   assign s_axi_arready = arReady_q;
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rresp = rResp_q;
   assign s_axi_rdata = rData_q;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   cfg_reset_a: assert property (disable iff (1'b0) rst |=> (cfgQ == PSC_CFG_RESET)) // see R1
      else $error("config word not cleared by reset");
   pin_route_a: assert property (cfgQ.standbyIndicatorRoute |=> pinFour.oe && (pinFour.val == !$past(inStandby))) // see R4
      else $error("pin four not showing standby indicator");
   pin_low_a: assert property (cfgQ.standbyIndicatorRoute && inStandby |=> !pinFour.val) // see R5
      else $error("standby indicator not low in standby");
   pin_follow_a: assert property (!cfgQ.standbyIndicatorRoute |=> pinFour == $past(pinFourCtrl)) // see R6
      else $error("pin four not following its own settings");
   cal_range_a: assert property ($rose(cfgQ.calRangeDouble) |=> calRangeDouble) // see R3
      else $error("calibration doubler not applied");
   osc_keep_a: assert property (inStandby && cfgQ.standbyDiagKeep && (|ovUvErrEnable) && clkSelInternal // see R10
      |=> intOscEnable)
      else $error("oscillator not kept in standby");
   osc_stop_a: assert property (inStandby && !cfgQ.standbyDiagKeep |=> !intOscEnable) // see R9
      else $error("oscillator left on without need");
   ovuv_osc_a: assert property (clkSelInternal && inStandby && !oscKeep |=> ovUvDetectEnable == '0) // see R8
      else $error("voltage detection without oscillator");
   diag_keep_a: assert property (inStandby && cfgQ.standbyDiagKeep && clkSelInternal // see R7
      |=> ovUvDetectEnable == $past(ovUvErrEnable))
      else $error("diagnostics dropped in standby");
   wr_latency_a: assert property (awTake && wTake ##1 !s_axi_bvalid |=> s_axi_bvalid) // see R1
      else $error("write response late");

   route_c: cover property (cfgQ.standbyIndicatorRoute && inStandby ##1 !pinFour.val);
   keep_c: cover property (inStandby && oscKeep ##1 intOscEnable);
   write_c: cover property (cfgWrite ##1 s_axi_bvalid);
   read_c: cover property (arTake && hitCfg ##1 s_axi_rvalid);
endmodule : psc_top

// ===== common/psc_pkg.sv
// ----------------------------------------
// Standby configuration register constants
// ----------------------------------------
package psc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [9:0] PSC_CFG_IDX = 10'h039;
   localparam logic [9:0] PSC_STAT_IDX = 10'h040;
   localparam int PSC_ADDR_W = 12;
   // Configuration word layout and reset
   localparam logic [15:0] PSC_CFG_RESET = 16'h0000;
   localparam logic [15:0] PSC_CFG_WMASK = 16'he1ff; // Bits 12:9 read as zero
   localparam int PSC_RSVD_TOP_BIT = 15;
   localparam int PSC_REG_OFF_BIT = 14;
   localparam int PSC_CAL_DBL_BIT = 13;
   localparam int PSC_ROUTE_BIT = 8;
   localparam int PSC_DIAG_KEEP_BIT = 7;
   // Status word layout and reset
   localparam logic [2:0] PSC_STAT_RESET = 3'h0;
   localparam int PSC_STAT_OSC_BIT = 0;
   localparam int PSC_STAT_IND_BIT = 1;
   localparam int PSC_STAT_DIAG_BIT = 2;
   // AXI responses
   localparam logic [1:0] PSC_RESP_OKAY = 2'h0;
   localparam logic [1:0] PSC_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic rsvdTop;
      logic analogRegulatorOff;
      logic calRangeDouble;
      logic [3:0] rsvdMid;
      logic standbyIndicatorRoute;
      logic standbyDiagKeep;
      logic [6:0] keepAlive;
   } psc_cfg_t;

   // Output pin drive: enable and level
   typedef struct packed {
      logic oe;
      logic val;
   } psc_pin_t;
endpackage : psc_pkg

// ===== logic/psc_cfg_word.sv
`timescale 1ns/100ps
// ----------------------------------------
// Byte-writable configuration word
// ----------------------------------------
module psc_cfg_word (
   input wire logic clk, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic we, // Write strobe
   input wire logic [15:0] wdata, // Write data
   input wire logic [1:0] wstrb, // Byte enables
   output psc_pkg::psc_cfg_t q // Stored word
);
   import psc_pkg::*;

   logic [15:0] word_q;
   logic [15:0] word_d;
   logic [15:0] laneMask;

   // One lane mask bit group per byte
   genvar b;
   generate
      for (b = 0; b < 2; b++) begin : g_lane
         assign laneMask[b*8 +: 8] = {8{we & wstrb[b]}} & PSC_CFG_WMASK[b*8 +: 8];
      end
   endgenerate

   // Read-only bits never take a write, so they stay zero
   assign word_d = (word_q & ~laneMask) | (wdata & laneMask);
   assign q = psc_cfg_t'(word_q);

   // Storage, cleared by reset
   always_ff @(posedge clk) begin
      if (rst) begin
         word_q <= PSC_CFG_RESET; // see R1
      end else begin
         word_q <= word_d;
      end
   end
endmodule : psc_cfg_word

// ===== verif/testbench.sv
`timescale 1ns/100ps
// ----------------------------------------
// Bench for the standby configuration block
// ----------------------------------------
module testbench;
   import psc_pkg::*;
   localparam logic [11:0] CFG_ADDR = {PSC_CFG_IDX, 2'b00};
   localparam logic [11:0] STAT_ADDR = {PSC_STAT_IDX, 2'b00};
   logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, data;
   logic [3:0] wstrb, ovUvErrEnable, ovUvDetectEnable, en;
   logic [1:0] bresp, rresp, resp;
   logic inStandby, clkSelInternal, extClkRunning, osc;
   logic analogRegulatorOff, calRangeDouble, intOscEnable;
   psc_pin_t pinFourCtrl, pinFour;
   int errCount, compares;

   psc_top u_psc_top (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .inStandby(inStandby),
      .pinFourCtrl(pinFourCtrl), .ovUvErrEnable(ovUvErrEnable), .clkSelInternal(clkSelInternal),
      .extClkRunning(extClkRunning), .pinFour(pinFour), .analogRegulatorOff(analogRegulatorOff),
      .calRangeDouble(calRangeDouble), .intOscEnable(intOscEnable), .ovUvDetectEnable(ovUvDetectEnable));

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   // Compare with case equality so an unknown never matches
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         errCount++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic results;
      $display("comparisons %0d mismatches %0d", compares, errCount);
      if (errCount == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   // Handshakes are sampled at the falling edge, where the registered readies are settled
   task automatic wr(input logic [11:0] a, input logic [15:0] d, output logic [1:0] r);
      logic ta, tw, tb;
      tb = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 50 && !tb; n++) begin
         @(negedge clk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid;
         r = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
      end
      if (!tb) begin
         errCount++;
         results();
      end
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, tr;
      tr = 1'b0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 50 && !tr; n++) begin
         @(negedge clk);
         ta = arvalid & arready;
         tr = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         if (tr) rready <= 1'b0;
      end
      if (!tr) begin
         errCount++;
         results();
      end
   endtask : rd

   // Outputs lag their inputs by one register stage
   task automatic settle;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask : settle

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      {inStandby, clkSelInternal, extClkRunning, pinFourCtrl, ovUvErrEnable} = '0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(CFG_ADDR, data, resp);
      chk("config reset", 32'h0, data);
      chk("read resp", {30'h0, PSC_RESP_OKAY}, {30'h0, resp});
      // Reserved bit 15 kept at zero; bits 12:9 must read back zero
      wr(CFG_ADDR, 16'h7fff, resp);
      chk("write resp", {30'h0, PSC_RESP_OKAY}, {30'h0, resp});
      rd(CFG_ADDR, data, resp);
      chk("config word", 32'h61ff, data);
      settle;
      chk("regulator off", 32'h1, {31'h0, analogRegulatorOff});
      chk("cal double", 32'h1, {31'h0, calRangeDouble});
      // Routed indicator ignores the ordinary settings
      for (int s = 0; s < 2; s++) begin
         @(posedge clk);
         pinFourCtrl <= 2'b01;
         inStandby <= s[0];
         settle;
         chk("routed pin", {30'h0, 1'b1, ~s[0]}, {30'h0, pinFour});
      end
      // Routing clear: standby high so a leaked indicator would show
      wr(CFG_ADDR, 16'h0000, resp);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         pinFourCtrl <= i[1:0];
         inStandby <= 1'b1;
         settle;
         chk("plain pin", i, {30'h0, pinFour});
      end
      // Cleared bits must also drop their outputs again
      chk("regulator on", 32'h0, {31'h0, analogRegulatorOff});
      chk("cal single", 32'h0, {31'h0, calRangeDouble});
      // Every mix of keep bit, standby, clock choice, enables and external clock
      for (int i = 0; i < 32; i++) begin
         if (i[3:0] == 4'h0) wr(CFG_ADDR, {8'h00, i[4], 7'h00}, resp);
         @(posedge clk);
         inStandby <= i[3];
         clkSelInternal <= i[2];
         ovUvErrEnable <= i[1] ? 4'h5 : 4'h0;
         extClkRunning <= i[0];
         settle;
         osc = !i[3] | (i[4] & i[1] & i[2]);
         en = (i[1] ? 4'h5 : 4'h0) & {4{(!i[3] | i[4]) & (i[2] ? osc : i[0])}};
         chk("osc enable", {31'h0, osc}, {31'h0, intOscEnable});
         chk("detectors", {28'h0, en}, {28'h0, ovUvDetectEnable});
      end
      // Standby, keep set, internal clock, enables on: oscillator and diagnostics live, indicator low
      rd(STAT_ADDR, data, resp);
      chk("status", 32'h5, data);
      // Unmapped read and read-only write are refused and change nothing
      rd(12'h004, data, resp);
      chk("unmapped resp", {30'h0, PSC_RESP_SLVERR}, {30'h0, resp});
      chk("unmapped data", 32'h0, data);
      wr(STAT_ADDR, 16'h2000, resp);
      chk("status write", {30'h0, PSC_RESP_SLVERR}, {30'h0, resp});
      rd(CFG_ADDR, data, resp);
      chk("config kept", 32'h0080, data);
      // Mid-run reset clears the keep bit, so the oscillator may stop again
      @(posedge clk);
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(CFG_ADDR, data, resp);
      chk("config after reset", 32'h0, data);
      settle;
      chk("osc after reset", 32'h0, {31'h0, intOscEnable});
      chk("detectors after reset", 32'h0, {28'h0, ovUvDetectEnable});
      results();
   end
endmodule : testbench
